// ### dv/tb.sv
// self-checking testbench for the lifetime timer
`timescale 1ns/1ps
`include "ltc_regs.svh"
module tb;
  logic        aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, timer_irq;
  logic [1:0]  bresp, rresp, r;
  logic        lp_osc_tick, xtal_tick, prec_osc_tick;
  logic [17:0] irq_events;
  logic [31:0] v1, v2, c0, c1, ld, ct;
  logic        up, per, ok;
  int          errors, cmp_count, cyc, seed, code;
  int          rc[7] = '{32'h80, 32'h82, 32'h84, 32'h88, 32'h280, 32'h480, 32'h680};
  int          dv[7] = '{1, 1, 16, 256, 4, 5, 3};

  ltc_top i_ltc_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .lp_osc_tick(lp_osc_tick), .xtal_tick(xtal_tick), .prec_osc_tick(prec_osc_tick),
    .irq_events(irq_events), .timer_irq(timer_irq)
  );

  always #50 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    lp_osc_tick <= (cyc % 4 == 0);
    xtal_tick <= (cyc % 5 == 0);
    prec_osc_tick <= (cyc % 3 == 0);
    if (cyc == 40000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic rate_ok(input logic [31:0] n, input int d);
    int e;
    e = (40 * d + 3) / d;
    rate_ok = (n + 1 >= e) && (n <= e + 1);
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin
        awvalid <= 0;
        ad = 1;
      end
      if (wready === 1'b1 && !wd) begin
        wvalid <= 0;
        wd = 1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task automatic start(input logic [31:0] l, input logic [31:0] c);
    wr(`LTC_ADDR_CTRL, 32'h0);
    wr(`LTC_ADDR_CLR, 32'h0);
    wr(`LTC_ADDR_LOAD, l);
    wr(`LTC_ADDR_CTRL, c);
    repeat (10) @(posedge aclk);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (timer_irq !== 1'b1 && n < 300) begin
      @(posedge aclk);
      n = n + 1;
    end
    chk("irq raised", 32'h1, {31'h0, timer_irq});
  endtask

  task automatic print_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    aresetn = 0; awaddr = 0; wdata = 0; wstrb = 4'hf; awprot = 0; arprot = 0;
    awvalid = 0; wvalid = 0; bready = 0; araddr = 0; arvalid = 0; rready = 0;
    lp_osc_tick = 0; xtal_tick = 0; prec_osc_tick = 0; irq_events = 0;
    errors = 0; cmp_count = 0; cyc = 0; seed = 9065; aclk = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 6; i++) begin
      rd(`LTC_ADDR_LOAD + 32'(4 * i), v1);
      chk("reset value", 32'h0, v1);
      chk("reset resp", {30'h0, `LTC_RESP_OKAY}, {30'h0, r});
    end
    wr(`LTC_ADDR_VLO, $random(seed));
    rd(`LTC_ADDR_VLO, v1);
    chk("value low read-only", 32'h0, v1);
    wr(32'hffff0318, $random(seed));
    chk("unmapped write", {30'h0, `LTC_RESP_SLVERR}, {30'h0, r});
    rd(32'hffff0318, v1);
    chk("unmapped read", {30'h0, `LTC_RESP_SLVERR}, {30'h0, r});
    v1 = $random(seed);
    wr(`LTC_ADDR_CAP, v1);
    rd(`LTC_ADDR_CAP, v2);
    chk("capture rw", {16'h0, v1[15:0]}, v2);
    v1 = $random(seed);
    wr(`LTC_ADDR_CTRL, v1);
    rd(`LTC_ADDR_CTRL, v2);
    chk("control mask", v1 & `LTC_CTRL_MASK, v2);
    for (int m = 0; m < 4; m++) begin
      up = m[1];
      per = m[0];
      v1 = 20 + ($random(seed) & 15);
      ld = up ? 32'hffff - v1 : v1;
      start(ld, 32'h80 | {per, 6'h0} | {up, 8'h0});
      chk("irq idle after start", 32'h0, {31'h0, timer_irq});
      wait_irq();
      rd(`LTC_ADDR_VLO, v1);
      if (per)
        ok = up ? v1[15:0] >= ld[15:0] : v1[15:0] <= ld[15:0];
      else
        ok = up ? v1[15:0] < 16'h100 : v1[15:0] > 16'hff00;
      chk("terminal count", 32'h1, {31'h0, ok});
      wr(`LTC_ADDR_CLR, $random(seed));
      repeat (8) @(posedge aclk);
      chk("irq cleared", 32'h0, {31'h0, timer_irq});
      rd(`LTC_ADDR_VLO, v2);
      ok = up ? v2[15:0] >= ld[15:0] : v2[15:0] <= ld[15:0];
      chk("clear reload", 32'h1, {31'h0, ok});
    end
    for (int i = 0; i < 7; i++) begin
      start(32'hff00, rc[i]);
      repeat (2 * dv[i]) @(posedge aclk);
      rd(`LTC_ADDR_VLO, v1);
      repeat (40 * dv[i]) @(posedge aclk);
      rd(`LTC_ADDR_VLO, v2);
      v1 = v1 - v2;
      chk("count rate", 32'h1, {31'h0, rate_ok(v1, dv[i])});
    end
    start($random(seed), 32'h90);
    rd(`LTC_ADDR_VLO, v1);
    rd(`LTC_ADDR_VHI, v2);
    chk("48-bit from zero", 32'h1, {31'h0, v1 < 32'h100});
    chk("value high", 32'h0, v2);
    rd(`LTC_ADDR_VLO, v2);
    chk("48-bit counts up", 32'h1, {31'h0, v2 > v1});
    start(32'hf000, 32'h80);
    for (int k = 0; k < 20; k++) begin
      code = k < 18 ? k : 20;
      ct = 32'h20080 | (code << 12) | (k == 19 ? 32'h10 : 32'h0);
      ok = code < 18 && code != 4 && code != 13 && k != 19;
      wr(`LTC_ADDR_CTRL, ct);
      repeat (6) @(posedge aclk);
      rd(`LTC_ADDR_CAP, c0);
      rd(`LTC_ADDR_VLO, v1);
      if (code < 18)
        irq_events[code] <= 1'b1;
      else
        irq_events <= 18'h3ffff;
      repeat (3) @(posedge aclk);
      rd(`LTC_ADDR_CAP, c1);
      rd(`LTC_ADDR_VLO, v2);
      irq_events <= 18'h0;
      if (ok)
        chk("capture taken", 32'h1,
            {31'h0, v1 >= c1 && c1 >= v2 && c1 !== c0});
      else
        chk("capture ignored", c0, c1);
    end
    wr(`LTC_ADDR_CTRL, 32'h0);
    repeat (6) @(posedge aclk);
    rd(`LTC_ADDR_VLO, v1);
    repeat (20) @(posedge aclk);
    rd(`LTC_ADDR_VLO, v2);
    chk("halted holds", v1, v2);
    print_verdict();
  end
endmodule

// ### rtl/ltc_pkg.sv
// types shared by the lifetime timer modules
package ltc_pkg;

  typedef struct packed {
    logic       cap_en;
    logic [4:0] ev_sel;
    logic       rsv11;
    logic [1:0] clk_sel;
    logic       count_up;
    logic       enable;
    logic       periodic;
    logic       rsv5;
    logic       mode48;
    logic [3:0] prescale;
  } ltc_ctrl_s;

  typedef struct packed {
    logic       clr_tgl;
    ltc_ctrl_s  ctrl;
    logic [15:0] load;
  } ltc_xfer_s;

  typedef enum logic [2:0] {
    LTC_R_LOAD = 3'h0,
    LTC_R_VLO  = 3'h1,
    LTC_R_VHI  = 3'h3,
    LTC_R_CTRL = 3'h2,
    LTC_R_CLR  = 3'h6,
    LTC_R_CAP  = 3'h7,
    LTC_R_NONE = 3'h5
  } ltc_reg_e;

  typedef struct packed {
    logic [14:0] div;
  } ltc_pre_s;

  typedef struct packed {
    logic        aw_full;
    logic [31:0] awaddr;
    logic        w_full;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] ctrl;
    logic [15:0] load;
    logic        clr_tgl;
    logic        clr_seen;
    logic        en_q;
    logic [47:0] cnt;
    logic        irq;
    logic        ev_q;
    logic [15:0] cap;
  } ltc_st_s;

endpackage

// ### rtl/ltc_prescale.sv
// prescaler turning the selected source tick into a count enable
`timescale 1ns/1ps
`include "ltc_regs.svh"
module ltc_prescale import ltc_pkg::*; #(
  parameter int DIV_W = 15
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       src_tick,
  input  wire logic [3:0] psel,
  output logic            cnt_en
);

  ltc_pre_s st;
  ltc_pre_s next_st;
  logic [14:0] lim;

  function automatic logic [14:0] ltc_pre_limit(input logic [3:0] sel);
    case (sel)
      `LTC_PRE_DIV16:  ltc_pre_limit = `LTC_LIM_DIV16;
      `LTC_PRE_DIV256: ltc_pre_limit = `LTC_LIM_DIV256;
      `LTC_PRE_DIV32K: ltc_pre_limit = `LTC_LIM_DIV32K;
      default:         ltc_pre_limit = `LTC_LIM_DIV1;
    endcase
  endfunction

  assign lim    = ltc_pre_limit(psel);
  assign cnt_en = run && src_tick && (st.div >= lim);

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.div = '0;
    end else if (src_tick) begin
      next_st.div = (st.div >= lim) ? 15'h0000 : st.div + 15'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_pre_gap16:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_en && psel == `LTC_PRE_DIV16 && run |=> !cnt_en)
    else $error("divide by 16 gave back to back enables");

endmodule

// ### rtl/ltc_regs.svh
// register addresses, field values, reset values and counts of the lifetime timer
`ifndef LTC_REGS_SVH
`define LTC_REGS_SVH

`define LTC_ADDR_LOAD   32'hffff0300
`define LTC_ADDR_VLO    32'hffff0304
`define LTC_ADDR_VHI    32'hffff0308
`define LTC_ADDR_CTRL   32'hffff030c
`define LTC_ADDR_CLR    32'hffff0310
`define LTC_ADDR_CAP    32'hffff0314

`define LTC_CTRL_MASK   32'h0003f7df
`define LTC_CTRL_RST    32'h00000000
`define LTC_LOAD_RST    16'h0000
`define LTC_CAP_RST     16'h0000
`define LTC_CNT_RST     48'h000000000000

`define LTC_CLK_CORE    2'h0
`define LTC_CLK_LPOSC   2'h1
`define LTC_CLK_XTAL    2'h2
`define LTC_CLK_PREC    2'h3

`define LTC_PRE_DIV1    4'h0
`define LTC_PRE_DIV16   4'h4
`define LTC_PRE_DIV256  4'h8
`define LTC_PRE_DIV32K  4'hf
`define LTC_LIM_DIV1    15'h0000
`define LTC_LIM_DIV16   15'h000f
`define LTC_LIM_DIV256  15'h00ff
`define LTC_LIM_DIV32K  15'h7fff

`define LTC_EV_RSV_A    5'h04
`define LTC_EV_RSV_B    5'h0d
`define LTC_EV_COUNT    5'h12

`define LTC_FULL16      16'hffff
`define LTC_FULL48      48'hffffffffffff

`define LTC_RESP_OKAY   2'h0
`define LTC_RESP_SLVERR 2'h2

`endif

// ### rtl/ltc_sync.sv
// two-stage double buffer carrying register data into the timer tick domain
`timescale 1ns/1ps
module ltc_sync #(
  parameter int W = 35
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ltc_sync_st_s;

  ltc_sync_st_s st;
  ltc_sync_st_s next_st;

  // both stages advance only on a timer tick
  always_comb begin
    next_st = st;
    if (tick) begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

  a_sync_hold:
  assert property (@(posedge aclk) disable iff (!aresetn) !tick |=> $stable(q))
    else $error("synced data moved without a timer tick");

endmodule

// ### rtl/ltc_top.sv
// lifetime timer with event capture behind an axi4-lite register slave
`timescale 1ns/1ps
`include "ltc_regs.svh"
// Function
// - writing control starts timer; control sets direction, mode and rate
// - interrupt when down count reaches zero or up count reaches full scale
// - any write to clear register clears pending interrupt
// - free-running mode wraps around at terminal count, no reload
// - periodic mode reloads from load register at terminal count
// - counter value readable any time, also while counting
// - each rising edge of selected event copies counter into capture register
// - event codes map to event inputs; codes 4, 13 and above 17 none
// - register data reach counter through two-stage buffer, two timer ticks
// - 48-bit mode counts up from zero; 16-bit mode up or down
// - clock source selectable of four; prescaler 1, 16, 256, 32768
// - value low holds 16 lsbs, value high 32 msbs, both read-only
// - counter reloads from load at terminal count in periodic mode and on clear write
// - clear reload, load and capture work only in 16-bit mode
// - control bits 10:9 select clock source
// - control bits 3:0 select prescaler
// - bit7 enable, bit6 periodic, bit4 48-bit, bit8 count up
// - bit17 capture enable, bits 16:12 event select
module ltc_top import ltc_pkg::*; (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        lp_osc_tick,
  input  wire logic        xtal_tick,
  input  wire logic        prec_osc_tick,
  input  wire logic [17:0] irq_events,
  output logic             timer_irq
);

  ltc_st_s   st;
  ltc_st_s   next_st;
  ltc_ctrl_s rc;
  ltc_xfer_s xin;
  ltc_xfer_s tq;
  logic      sync_tick;
  logic      src_tick;
  logic      run;
  logic      cnt_en;
  logic      start;
  logic      clr_apply;
  logic      term;
  logic      tc_evt;
  logic      ev_now;
  logic      cap_rise;
  logic      aw_hs;
  logic      ar_hs;

  function automatic ltc_reg_e ltc_dec(input logic [31:0] a);
    case (a)
      `LTC_ADDR_LOAD: ltc_dec = LTC_R_LOAD;
      `LTC_ADDR_VLO:  ltc_dec = LTC_R_VLO;
      `LTC_ADDR_VHI:  ltc_dec = LTC_R_VHI;
      `LTC_ADDR_CTRL: ltc_dec = LTC_R_CTRL;
      `LTC_ADDR_CLR:  ltc_dec = LTC_R_CLR;
      `LTC_ADDR_CAP:  ltc_dec = LTC_R_CAP;
      default:        ltc_dec = LTC_R_NONE;
    endcase
  endfunction

  function automatic logic [31:0] ltc_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    ltc_merge = r;
  endfunction

  function automatic logic ltc_clk_pick(input logic [1:0] sel, input logic lp,
                                        input logic xt, input logic pr);
    case (sel)
      `LTC_CLK_LPOSC: ltc_clk_pick = lp;
      `LTC_CLK_XTAL:  ltc_clk_pick = xt;
      `LTC_CLK_PREC:  ltc_clk_pick = pr;
      default:        ltc_clk_pick = 1'b1;
    endcase
  endfunction

  // source selection, register side steers the buffer tick
  assign rc        = ltc_ctrl_s'(st.ctrl[17:0]);
  assign sync_tick = ltc_clk_pick(rc.clk_sel, lp_osc_tick, xtal_tick, prec_osc_tick);
  assign src_tick  = ltc_clk_pick(tq.ctrl.clk_sel, lp_osc_tick, xtal_tick,
                                  prec_osc_tick);
  assign xin.clr_tgl = st.clr_tgl;
  assign xin.ctrl    = rc;
  assign xin.load    = st.load;

  ltc_sync #(
    .W ($bits(ltc_xfer_s))
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (sync_tick),
    .d       (xin),
    .q       (tq)
  );

  assign run = tq.ctrl.enable && st.en_q;

  ltc_prescale #(
    .DIV_W (15)
  ) u_pre (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (run),
    .src_tick (src_tick),
    .psel     (tq.ctrl.prescale),
    .cnt_en   (cnt_en)
  );

  // timer side decode
  assign start     = tq.ctrl.enable && !st.en_q;
  assign clr_apply = tq.clr_tgl != st.clr_seen;
  assign term      = tq.ctrl.mode48 ? (st.cnt == `LTC_FULL48) :
                     tq.ctrl.count_up ? (st.cnt[15:0] == `LTC_FULL16) :
                     (st.cnt[15:0] == 16'h0000);
  assign tc_evt    = cnt_en && term;
  assign ev_now    = (tq.ctrl.ev_sel < `LTC_EV_COUNT) && (tq.ctrl.ev_sel != `LTC_EV_RSV_A) &&
                     (tq.ctrl.ev_sel != `LTC_EV_RSV_B) && irq_events[tq.ctrl.ev_sel];
  assign cap_rise  = ev_now && !st.ev_q && tq.ctrl.cap_en && !tq.ctrl.mode48;

  assign awready   = !st.aw_full && !st.bvalid;
  assign wready    = !st.w_full && !st.bvalid;
  assign arready   = !st.rvalid;
  assign aw_hs     = awvalid && awready;
  assign ar_hs     = arvalid && arready;

  always_comb begin
    next_st = st;
    // write channels, taken in either order
    if (aw_hs) begin
      next_st.aw_full = 1'b1;
      next_st.awaddr  = awaddr;
    end
    if (wvalid && wready) begin
      next_st.w_full = 1'b1;
      next_st.wdata  = wdata;
      next_st.wstrb  = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_full && st.w_full && !st.bvalid) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `LTC_RESP_OKAY;
      case (ltc_dec(st.awaddr))
        LTC_R_LOAD: next_st.load = 16'(ltc_merge({16'h0000, st.load}, st.wdata, st.wstrb));
        LTC_R_CTRL: next_st.ctrl = ltc_merge(st.ctrl, st.wdata, st.wstrb) & `LTC_CTRL_MASK;
        LTC_R_CLR:  next_st.clr_tgl = !st.clr_tgl;
        LTC_R_CAP:  next_st.cap = 16'(ltc_merge({16'h0000, st.cap}, st.wdata, st.wstrb));
        LTC_R_VLO:  next_st.bresp = `LTC_RESP_OKAY;
        LTC_R_VHI:  next_st.bresp = `LTC_RESP_OKAY;
        default:    next_st.bresp = `LTC_RESP_SLVERR;
      endcase
    end
    // read channel
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `LTC_RESP_OKAY;
      case (ltc_dec(araddr))
        LTC_R_VLO:  next_st.rdata = {16'h0000, st.cnt[15:0]};
        LTC_R_VHI:  next_st.rdata = tq.ctrl.mode48 ? st.cnt[47:16] : 32'h00000000;
        LTC_R_CTRL: next_st.rdata = st.ctrl;
        LTC_R_CAP:  next_st.rdata = {16'h0000, st.cap};
        LTC_R_LOAD: next_st.rdata = 32'h00000000;
        LTC_R_CLR:  next_st.rdata = 32'h00000000;
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = `LTC_RESP_SLVERR;
        end
      endcase
    end
    // counter
    next_st.en_q     = tq.ctrl.enable;
    next_st.clr_seen = tq.clr_tgl;
    if (start) begin
      next_st.cnt = tq.ctrl.mode48 ? `LTC_CNT_RST : {32'h00000000, tq.load};
    end else if (clr_apply && !tq.ctrl.mode48) begin
      next_st.cnt = {32'h00000000, tq.load};
    end else if (cnt_en) begin
      if (tq.ctrl.mode48) begin
        next_st.cnt = st.cnt + 48'h000000000001;
      end else if (term && tq.ctrl.periodic) begin
        next_st.cnt = {32'h00000000, tq.load};
      end else if (tq.ctrl.count_up) begin
        next_st.cnt = {32'h00000000, st.cnt[15:0] + 16'h0001};
      end else begin
        next_st.cnt = {32'h00000000, st.cnt[15:0] - 16'h0001};
      end
    end
    // interrupt level, set wins over clear
    if (clr_apply) begin
      next_st.irq = 1'b0;
    end
    if (tc_evt) begin
      next_st.irq = 1'b1;
    end
    // capture has priority over a software write
    next_st.ev_q = ev_now;
    if (cap_rise) begin
      next_st.cap = st.cnt[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st      <= '0;
      st.ctrl <= `LTC_CTRL_RST;
      st.load <= `LTC_LOAD_RST;
      st.cap  <= `LTC_CAP_RST;
      st.cnt  <= `LTC_CNT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bvalid    = st.bvalid;
  assign bresp     = st.bresp;
  assign rvalid    = st.rvalid;
  assign rdata     = st.rdata;
  assign rresp     = st.rresp;
  assign timer_irq = st.irq;

  a_irq_on_tc:
  assert property (@(posedge aclk) disable iff (!aresetn) tc_evt |=> timer_irq)
    else $error("terminal count did not raise the interrupt");

  a_clr_drops_irq:
  assert property (@(posedge aclk) disable iff (!aresetn)
    clr_apply && !tc_evt |=> !timer_irq)
    else $error("clear did not drop the interrupt");

  a_free_wraps:
  assert property (@(posedge aclk) disable iff (!aresetn)
    tc_evt && !clr_apply && !tq.ctrl.mode48 && !tq.ctrl.periodic && !tq.ctrl.count_up
    |=> st.cnt[15:0] == `LTC_FULL16)
    else $error("free running down count did not wrap to full scale");

  a_periodic_load:
  assert property (@(posedge aclk) disable iff (!aresetn)
    tc_evt && !tq.ctrl.mode48 && tq.ctrl.periodic |=> st.cnt[15:0] == $past(tq.load))
    else $error("periodic mode did not reload");

  a_low_readback:
  assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && araddr == `LTC_ADDR_VLO |=> rvalid && rdata[15:0] == $past(st.cnt[15:0]))
    else $error("value read does not match counter");

  a_capture_copy:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cap_rise |=> st.cap == $past(st.cnt[15:0]) && st.cnt == $past(next_st.cnt))
    else $error("capture did not copy the counter");

  a_mode48_up:
  assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_en && tq.ctrl.mode48 && !start |=> st.cnt == $past(st.cnt) + 48'h000000000001)
    else $error("48-bit mode did not count up by one");

  a_idle_holds:
  assert property (@(posedge aclk) disable iff (!aresetn)
    !tq.ctrl.enable && !clr_apply |=> $stable(st.cnt))
    else $error("counter moved while disabled");

  a_write_resp:
  assert property (@(posedge aclk) disable iff (!aresetn)
    st.aw_full && st.w_full && !st.bvalid |=> bvalid && !awready && !wready)
    else $error("write response missing");

endmodule
